// ==== pfs_pkg.sv ====
package pfs_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int NUM_PH   = 4;
   localparam int NUM_RAIL = 2;
   // phase index order: 0 = 1A, 1 = 1B, 2 = 2A, 3 = 3A

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int T_FLT_BASE_US    = 15;
   localparam int T_FLT_PER_PH_US  = 3;
   localparam int T_RAIL_BASE_US   = 10;
   localparam int T_RAIL_PER_PH_US = 3;
   localparam int CLF_SW_CYCLES    = 4;
   // longest times, worst case with all phases configured
   localparam int FLT_MAX_CYC  =
      (T_FLT_BASE_US + T_FLT_PER_PH_US * NUM_PH) * CLK_MHZ;
   localparam int RAIL_MAX_CYC =
      (T_RAIL_BASE_US + T_RAIL_PER_PH_US * NUM_PH) * CLK_MHZ;
   // pin to output: two sync stages, output flop, one spare cycle
   localparam int PIPE_CYC     = 4;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] RST_OFF  = 4'h0;
   localparam logic [1:0] RST_RAIL = 2'h0;
   localparam logic [3:0] RST_OUT  = 4'h0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RESP_IGNORE = 2'h0,
      RESP_PHASE  = 2'h1,
      RESP_RAIL   = 2'h2
   } pfs_resp_t;

   typedef struct packed {
      logic [3:0] pwm_drive_out;
      logic [3:0] sync_rect_enable;
   } pfs_drive_t;

   typedef struct packed {
      logic [2:0] active_phase_count;
      logic [3:0] phase_rail;
      logic [7:0] ext_resp;
   } pfs_cfg_t;
endpackage : pfs_pkg

// ==== pfs_sync.sv ====
`timescale 1ns/100ps
module pfs_sync #(
   parameter int W = 4
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : pfs_sync

// ==== pfs_shutdown.sv ====
// Contract
// [R01] Faults are caught by dedicated logic that never waits on the monitoring sequencer.
// [R02] A high external fault pin disables its drive output within 15 plus 3 per phase microseconds.
// [R03] A current comparator trip disables the first affected drive output within 4 switching cycles.
// [R04] A comparator fault disables all other drive and rectifier outputs of that rail within 10 plus 3 per phase microseconds.
// [R05] Each external fault pin counts as asserted while it is high.
// [R06] Rectifier enables are high to enable and are forced low on shutdown.
// [R07] Comparator 2 watches stage 1B, comparator 3 stage 2A and comparator 4 stage 3A.
// [R08] The block sits in reset while the reset input is low and leaves it when it goes high.
// [R09] The reaction to an external fault is picked from that fault's response code.
// [R10] Disabled outputs of a faulted rail stay off until re-enabled or reset.
`timescale 1ns/100ps
module pfs_shutdown
   import pfs_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                resetn,
   input  wire logic [3:0]          ext_fault_in,
   input  wire logic [3:0]          cmp_trip,
   input  wire pfs_pkg::pfs_drive_t drive_in,
   input  wire pfs_pkg::pfs_cfg_t   cfg,
   input  wire logic [1:0]          rail_reenable,
   output pfs_pkg::pfs_drive_t      drive_out,
   output logic [3:0]               phase_off,
   output logic [1:0]               rail_faulted
);
   import pfs_pkg::*;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [3:0] ext_s;
   logic [3:0] cmp_s;
   logic [3:0] cmp_ph;
   logic [3:0] ext_hit;
   logic [3:0] ext_rail;
   logic [3:0] active;
   logic [3:0] reen_ph;
   logic [1:0] rail_trip;
   logic [3:0] peer_off;
   logic [3:0] next_phase_off;
   logic [1:0] next_rail_faulted;

   // pins and comparator outputs are asynchronous to this clock
   pfs_sync #(.W(4)) u_ext_sync (
      .clock  (clock),
      .resetn (resetn),
      .din    (ext_fault_in),
      .dout   (ext_s)
   );

   pfs_sync #(.W(4)) u_cmp_sync (
      .clock  (clock),
      .resetn (resetn),
      .din    (cmp_trip),
      .dout   (cmp_s)
   );

   // cmp_trip bit k is comparator k+1; comparator k+1 senses phase k
   assign cmp_ph = cmp_s; // [R07]

   // ---------------------------------------------------------------
   // fault decode
   // ---------------------------------------------------------------
   always_comb begin
      rail_trip = '0;
      for (int p = 0; p < NUM_PH; p++) begin
         active[p]   = (3'(p) < cfg.active_phase_count);
         reen_ph[p]  = rail_reenable[cfg.phase_rail[p]];
         // high level is the asserted state of the pin
         ext_hit[p]  = ext_s[p] &&
                       (cfg.ext_resp[2*p +: 2] != RESP_IGNORE); // [R05] [R09]
         // code 3 is unassigned; treated as the safer rail shutdown
         ext_rail[p] = ext_s[p] && cfg.ext_resp[2*p+1]; // [R09]
         if (cmp_ph[p] || ext_rail[p]) begin
            rail_trip[cfg.phase_rail[p]] = 1'b1; // [R04]
         end
      end
   end

   // set wins over re-enable, so a fault in the re-enable cycle sticks
   always_comb begin
      for (int p = 0; p < NUM_PH; p++) begin
         // rail_trip is complete here, so every peer sees the whole rail
         peer_off[p]       = rail_trip[cfg.phase_rail[p]]; // [R04]
         next_phase_off[p] = (phase_off[p] && !reen_ph[p]) ||
                             ext_hit[p] || cmp_ph[p] ||
                             peer_off[p]; // [R10] [R03]
      end
      for (int r = 0; r < NUM_RAIL; r++) begin
         next_rail_faulted[r] = (rail_faulted[r] && !rail_reenable[r]) ||
                                rail_trip[r]; // [R10]
      end
   end

   // ---------------------------------------------------------------
   // latches
   // ---------------------------------------------------------------
   // no dependency on any sampling sequence: straight from the pins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase_off    <= RST_OFF; // [R08]
         rail_faulted <= RST_RAIL;
      end else begin
         phase_off    <= next_phase_off; // [R01]
         rail_faulted <= next_rail_faulted;
      end
   end

   // ---------------------------------------------------------------
   // output gating
   // ---------------------------------------------------------------
   // gated by next_ to save a cycle of latency on the first trip
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         drive_out.pwm_drive_out    <= RST_OUT; // [R08]
         drive_out.sync_rect_enable <= RST_OUT;
      end else begin
         drive_out.pwm_drive_out    <= drive_in.pwm_drive_out &
                                       ~next_phase_off & active; // [R02]
         drive_out.sync_rect_enable <= drive_in.sync_rect_enable &
                                       ~next_phase_off & active; // [R06]
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // one cycle from a rail trip to all peers dark, far inside the budget
   AST_BUDGET: assert property (@(posedge clock) disable iff (!resetn) // [R04]
      (|peer_off) |=>
      (((drive_out.pwm_drive_out | drive_out.sync_rect_enable) &
        $past(peer_off)) == 4'h0))
      else $error("rail peers not disabled after a rail trip");

   AST_RESET_EXIT: assert property (@(posedge clock) disable iff (!resetn) // [R08]
      $rose(resetn) |-> (phase_off == RST_OFF) && (rail_faulted == RST_RAIL))
      else $error("fault state not cleared by reset");

   for (genvar r = 0; r < NUM_RAIL; r++) begin : g_ast_rail
      AST_RAIL_HOLD: assert property ( // [R10]
         @(posedge clock) disable iff (!resetn)
         rail_faulted[r] && !rail_reenable[r] |=> rail_faulted[r])
         else $error("faulted rail released without re-enable");

      AST_RAIL_CLEAR: assert property ( // [R10]
         @(posedge clock) disable iff (!resetn)
         rail_faulted[r] && rail_reenable[r] && !rail_trip[r]
         |=> !rail_faulted[r])
         else $error("rail re-enable did not clear the rail fault");
   end

   for (genvar p = 0; p < NUM_PH; p++) begin : g_ast
      sequence s_pin_held;
         ext_fault_in[p] [*3];
      endsequence

      sequence s_cmp_held;
         cmp_trip[p] [*3];
      endsequence

      property p_off_after(s);
         @(posedge clock) disable iff (!resetn)
         s |=> !drive_out.pwm_drive_out[p] && !drive_out.sync_rect_enable[p];
      endproperty

      AST_PIN_OFF: assert property ( // [R02] [R05]
         @(posedge clock) disable iff (!resetn)
         s_pin_held and (cfg.ext_resp[2*p +: 2] != RESP_IGNORE) [*3]
         |=> !drive_out.pwm_drive_out[p])
         else $error("fault pin did not disable drive");

      AST_CMP_FIRST: assert property (p_off_after(s_cmp_held)) // [R03] [R07]
         else $error("comparator trip did not disable its phase");

      AST_PEER_OFF: assert property ( // [R04]
         @(posedge clock) disable iff (!resetn)
         peer_off[p] |=> phase_off[p])
         else $error("rail peer not latched off");

      AST_EXT_RAIL: assert property ( // [R09]
         @(posedge clock) disable iff (!resetn)
         ext_s[p] && cfg.ext_resp[2*p+1] |=> rail_faulted[$past(cfg.phase_rail[p])])
         else $error("rail response code did not fault the rail");

      // inactive phases are held low by the active mask, but their latches still set on faults
      AST_INACTIVE: assert property ( // [R06]
         @(posedge clock) disable iff (!resetn)
         !active[p] |=> !drive_out.pwm_drive_out[p] &&
                        !drive_out.sync_rect_enable[p])
         else $error("inactive phase driven");

      AST_PASS: assert property ( // [R06]
         @(posedge clock) disable iff (!resetn)
         !next_phase_off[p] && active[p] |=>
         (drive_out.sync_rect_enable[p] == $past(drive_in.sync_rect_enable[p])) &&
         (drive_out.pwm_drive_out[p] == $past(drive_in.pwm_drive_out[p])))
         else $error("healthy phase not passed through");

      AST_CMP_RAIL: assert property ( // [R04]
         @(posedge clock) disable iff (!resetn)
         cmp_s[p] |=> rail_faulted[$past(cfg.phase_rail[p])])
         else $error("comparator trip did not fault the rail");

      AST_SRE_LOW: assert property ( // [R06]
         @(posedge clock) disable iff (!resetn)
         phase_off[p] && !reen_ph[p] |=> !drive_out.sync_rect_enable[p])
         else $error("rectifier enable high on a disabled phase");

      AST_IGNORE: assert property ( // [R09]
         @(posedge clock) disable iff (!resetn)
         !phase_off[p] && !cmp_s[p] && !rail_trip[cfg.phase_rail[p]] &&
         (cfg.ext_resp[2*p +: 2] == RESP_IGNORE) |=> !phase_off[p])
         else $error("ignored fault code disabled a phase");

      AST_LATCHED: assert property ( // [R10]
         @(posedge clock) disable iff (!resetn)
         phase_off[p] && !reen_ph[p] |=> phase_off[p])
         else $error("disabled phase released without re-enable");

      AST_REENABLE: assert property ( // [R10] [R01]
         @(posedge clock) disable iff (!resetn)
         phase_off[p] && reen_ph[p] && !ext_s[p] && !cmp_s[p] &&
         !rail_trip[cfg.phase_rail[p]] |=> !phase_off[p])
         else $error("re-enable did not release the phase");
   end
endmodule : pfs_shutdown

// ==== pfs_partner.sv ====
`timescale 1ns/100ps
module pfs_partner (
   input  wire logic [3:0] fault_req,
   input  wire logic [3:0] trip_req,
   output logic      [3:0] ext_fault_in,
   output logic      [3:0] cmp_trip
);
   // ------------------------------------------------------------
   // fault sources
   // ------------------------------------------------------------
   // pins are plain levels, high while the fault stands
   assign ext_fault_in = fault_req;
   // bit k is comparator k+1, fed by the current sense of phase k
   assign cmp_trip     = trip_req;
endmodule : pfs_partner

// ==== test_pwm_fault_shutdown.sv ====
`timescale 1ns/100ps
module test_pwm_fault_shutdown;
   import pfs_pkg::*;
   logic               clock = 1'b0;
   logic               resetn = 1'b0;
   logic [3:0]         fault_req = 4'h0;
   logic [3:0]         trip_req = 4'h0;
   logic [1:0]         rail_reenable = 2'h0;
   logic [3:0]         ext_fault_in;
   logic [3:0]         cmp_trip;
   logic [3:0]         phase_off;
   logic [1:0]         rail_faulted;
   pfs_drive_t         drive_out;
   // phases 0,1 on rail 0; resp: 1A phase, 1B rail, 2A ignore, 3A phase
   pfs_cfg_t           cfg = '{3'h4, 4'hc, 8'h49};
   pfs_drive_t         drive_in = 8'hff;
   logic [3:0]         act_mask = 4'hf;
   int                 err_count = 0;
   int                 num_checks = 0;
   always #5 clock = ~clock;
   pfs_partner fsrc (.fault_req(fault_req), .trip_req(trip_req),
      .ext_fault_in(ext_fault_in), .cmp_trip(cmp_trip));
   pfs_shutdown dut (.clock(clock), .resetn(resetn),
      .ext_fault_in(ext_fault_in), .cmp_trip(cmp_trip),
      .drive_in(drive_in), .cfg(cfg), .rail_reenable(rail_reenable),
      .drive_out(drive_out), .phase_off(phase_off),
      .rail_faulted(rail_faulted));
   task chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // wait past sync and gating, then judge outputs and latches
   task settle(input logic [3:0] off, input logic [1:0] rail);
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(drive_out, drive_in & {2{~off & act_mask}});
      chk({2'h0, rail_faulted, phase_off}, {2'h0, rail, off});
   endtask : settle
   task step(input logic [3:0] f, input logic [3:0] t,
             input logic [3:0] off, input logic [1:0] rail);
      @(posedge clock);
      fault_req <= f;
      trip_req  <= t;
      settle(off, rail);
   endtask : step
   task pulse_reen(input logic [1:0] m, input logic [3:0] off,
                   input logic [1:0] rail);
      @(posedge clock);
      rail_reenable <= m;
      @(posedge clock);
      rail_reenable <= 2'h0;
      settle(off, rail);
   endtask : pulse_reen
   // pins drop first: the latches must hold until the re-enable pulse
   task release_all(input logic [3:0] off, input logic [1:0] rail);
      step(4'h0, 4'h0, off, rail);
      pulse_reen(2'h3, 4'h0, 2'h0);
   endtask : release_all
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      repeat (19) @(posedge clock);
      @(negedge clock);
      chk(drive_out, 8'h00);
      @(posedge clock);
      resetn <= 1'b1;
      settle(4'h0, 2'h0);
   endtask : t_reset
   task t_ext_phase;
      step(4'h1, 4'h0, 4'h1, 2'h0);
      // set wins: release is refused while the pin stays high
      pulse_reen(2'h3, 4'h1, 2'h0);
      release_all(4'h1, 2'h0);
   endtask : t_ext_phase
   task t_ext_rail;
      step(4'h2, 4'h0, 4'h3, 2'h1);
      release_all(4'h3, 2'h1);
      step(4'h4, 4'h0, 4'h0, 2'h0);
      release_all(4'h0, 2'h0);
   endtask : t_ext_rail
   task t_cmp;
      step(4'h0, 4'h8, 4'hc, 2'h2);
      release_all(4'hc, 2'h2);
      step(4'h0, 4'h2, 4'h3, 2'h1);
      step(4'h0, 4'h6, 4'hf, 2'h3);
      step(4'h0, 4'h0, 4'hf, 2'h3);
      // one rail at a time: the other must stay latched
      pulse_reen(2'h2, 4'h3, 2'h1);
      pulse_reen(2'h1, 4'h0, 2'h0);
   endtask : t_cmp
   // three phases, code 3 on 1A, uneven raw drive pattern
   task t_inactive;
      @(posedge clock);
      cfg      <= '{3'h3, 4'hc, 8'h4b};
      act_mask <= 4'h7;
      drive_in <= 8'h5f;
      settle(4'h0, 2'h0);
      step(4'h1, 4'h0, 4'h3, 2'h1);
      release_all(4'h3, 2'h1);
      @(posedge clock);
      cfg      <= '{3'h4, 4'hc, 8'h49};
      act_mask <= 4'hf;
      drive_in <= 8'hff;
   endtask : t_inactive
   task t_mid_reset;
      step(4'h1, 4'h0, 4'h1, 2'h0);
      @(posedge clock);
      resetn    <= 1'b0;
      fault_req <= 4'h0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(drive_out, 8'h00);
      chk({2'h0, rail_faulted, phase_off}, 8'h00);
      @(posedge clock);
      resetn <= 1'b1;
      settle(4'h0, 2'h0);
   endtask : t_mid_reset
   initial begin
      t_reset();
      t_ext_phase();
      t_ext_rail();
      t_cmp();
      t_inactive();
      t_mid_reset();
      stop_test();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clock);
      err_count++;
      stop_test();
   end
endmodule : test_pwm_fault_shutdown
